//--- design/charge_cycle_timing_and_status.sv
// charge cycle timing, status flags, shipping mode and indicator pin
// assumes comparator outcomes arrive asynchronously and a simple strobe register port
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "charge_defines.svh"
module charge_cycle_timing_and_status #(
   parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
   parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic charge_ce_n,
   input wire charge_pkg::analog_in_t analog_in,
   output logic host_event,
   output logic battery_switch_on,
   output logic input_good_pin,
   output logic indicator_out,
   output logic indicator_oe
);
   // ==========================================
   // input synchronisers
   localparam int W = $bits(charge_pkg::analog_in_t) + 1;
   logic [W-1:0] sync1;
   logic [W-1:0] sync2;
   charge_pkg::analog_in_t ain;
   logic ce_n_s;

   always_ff @(posedge ref_clk) begin
      sync1 <= reset ? {1'b1, {(W-1){1'b0}}} : {charge_ce_n, analog_in};
      sync2 <= reset ? {1'b1, {(W-1){1'b0}}} : sync1;
   end
   assign ain = sync2[W-2:0];
   assign ce_n_s = sync2[W-1];

   // ==========================================
   // control register
   logic [15:0] ctrl;
   logic adapter_q;
   wire ctrl_wr = reg_wr && (reg_addr == `CTRL_ADDR);
   wire reg_reset_wr = ctrl_wr && reg_wdata[`CTRL_REG_RESET];
   wire adapter_rise = ain.adapter_present && !adapter_q;
   wire term_en = ctrl[`CTRL_TERM_EN];
   wire timer_en = ctrl[`CTRL_TIMER_EN];
   wire half_en = ctrl[`CTRL_HALF_RATE];
   wire sw_off = ctrl[`CTRL_SW_OFF];
   wire sw_delay = ctrl[`CTRL_SW_DELAY];
   wire [1:0] fast_charge_limit_sel = ctrl[`CTRL_FAST_LSB +: 2];
   wire [1:0] topoff_sel = ctrl[`CTRL_TOPOFF_LSB +: 2];
   wire [1:0] indicator_function_sel = ctrl[`CTRL_IND_LSB +: 2];

   always_ff @(posedge ref_clk) begin
      adapter_q <= reset ? 1'b0 : ain.adapter_present;
      if (reset || reg_reset_wr) begin
         ctrl <= `CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl <= reg_wdata & 16'h3f3f;
      end else if (adapter_rise) begin
         ctrl[`CTRL_SW_OFF] <= 1'b0;
      end
   end

   // ==========================================
   // limit lookups
   function automatic logic [16:0] fast_limit(input logic [1:0] sel);
      unique case (sel)
         2'b00: fast_limit = `SAFETY_5H_S;
         2'b01: fast_limit = `SAFETY_10H_S;
         2'b10: fast_limit = `SAFETY_15H_S;
         2'b11: fast_limit = `SAFETY_20H_S;
      endcase
   endfunction : fast_limit

   function automatic logic [15:0] topoff_limit(input logic [1:0] sel);
      unique case (sel)
         2'b00: topoff_limit = 16'h0000;
         2'b01: topoff_limit = `TOPOFF_15M_S;
         2'b10: topoff_limit = `TOPOFF_30M_S;
         2'b11: topoff_limit = `TOPOFF_45M_S;
      endcase
   endfunction : topoff_limit

   // ==========================================
   // time base
   logic sec_tick;
   logic blink_tick;
   logic half_phase;

   tick_divider #(.PERIOD(TICK_CYCLES)) u_sec (
      .ref_clk(ref_clk),
      .reset(reset),
      .tick(sec_tick)
   );

   // dedicated divider so the blink rate never follows the half-rate timers
   tick_divider #(.PERIOD(BLINK_HALF_CYCLES)) u_blink (
      .ref_clk(ref_clk),
      .reset(reset),
      .tick(blink_tick)
   );

   wire reg_active = ain.in_current_reg || ain.in_voltage_reg || ain.thermal_reg;
   wire half_active = half_en && reg_active;
   wire suspended = ain.fault_present;
   wire slow_tick = sec_tick && (!half_active || half_phase);

   always_ff @(posedge ref_clk) begin
      if (reset || !half_active) begin
         half_phase <= 1'b0;
      end else if (sec_tick) begin
         half_phase <= !half_phase;
      end
   end

   // ==========================================
   // charge cycle state machine
   charge_pkg::cycle_state_t state;
   charge_pkg::cycle_state_t next_state;
   logic [16:0] safety_cnt;
   logic [15:0] topoff_cnt;
   logic [15:0] topoff_lim;
   logic charge_en_q;

   wire charge_en = ctrl[`CTRL_CHG_EN] && !ce_n_s && !sw_off;
   wire charge_en_rise = charge_en && !charge_en_q;
   wire [16:0] safety_lim = ain.vbat_above_low ? fast_limit(fast_charge_limit_sel)
                                               : `SAFETY_LOW_S;
   wire term_cond = term_en && !reg_active && ain.vbat_above_recharge
                    && ain.ichg_below_term;
   wire expire_cond = timer_en && (safety_cnt >= safety_lim);
   wire topoff_done = topoff_cnt >= topoff_lim;

   always_comb begin
      next_state = state;
      unique case (state)
         charge_pkg::ST_DISABLED: begin
            if (charge_en) begin
               next_state = charge_pkg::ST_CHARGING;
            end
         end
         charge_pkg::ST_CHARGING: begin
            if (!charge_en) begin
               next_state = charge_pkg::ST_DISABLED;
            end else if (expire_cond) begin
               next_state = charge_pkg::ST_FAULT;
            end else if (term_cond) begin
               next_state = (topoff_sel != 2'b00) ? charge_pkg::ST_TOPOFF
                                                  : charge_pkg::ST_DONE;
            end
         end
         charge_pkg::ST_TOPOFF: begin
            if (!charge_en) begin
               next_state = charge_pkg::ST_DISABLED;
            end else if (topoff_done) begin
               next_state = charge_pkg::ST_DONE;
            end else if (!ain.vbat_above_recharge) begin
               next_state = charge_pkg::ST_CHARGING;
            end
         end
         charge_pkg::ST_DONE: begin
            if (!charge_en) begin
               next_state = charge_pkg::ST_DISABLED;
            end else if (!ain.vbat_above_recharge) begin
               next_state = charge_pkg::ST_CHARGING;
            end
         end
         charge_pkg::ST_FAULT: begin
            if (!charge_en) begin
               next_state = charge_pkg::ST_DISABLED;
            end
         end
         default: next_state = charge_pkg::ST_DISABLED;
      endcase
   end

   wire in_charging = state == charge_pkg::ST_CHARGING;
   wire in_topoff = state == charge_pkg::ST_TOPOFF;
   wire in_done = state == charge_pkg::ST_DONE;
   wire in_fault = state == charge_pkg::ST_FAULT;
   wire enter_term = in_charging && (next_state == charge_pkg::ST_TOPOFF
                                     || next_state == charge_pkg::ST_DONE);
   wire topoff_end = in_topoff && (next_state == charge_pkg::ST_DONE);
   wire expire = in_charging && (next_state == charge_pkg::ST_FAULT);
   // entering top-off coincides with termination, so one pulse marks both
   wire next_event = enter_term || topoff_end || expire;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= charge_pkg::ST_DISABLED;
         charge_en_q <= 1'b0;
         host_event <= 1'b0;
      end else begin
         state <= next_state;
         charge_en_q <= charge_en;
         host_event <= next_event;
      end
   end

   // ==========================================
   // safety and top-off timers
   always_ff @(posedge ref_clk) begin
      if (reset || charge_en_rise) begin
         safety_cnt <= '0;
      end else if (in_charging && timer_en && !suspended && slow_tick) begin
         safety_cnt <= safety_cnt + 17'd1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         topoff_lim <= '0;
      end else if (enter_term) begin
         topoff_lim <= topoff_limit(topoff_sel);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset || charge_en_rise || enter_term || reg_reset_wr) begin
         topoff_cnt <= '0;
      end else if (in_topoff && !suspended && slow_tick) begin
         topoff_cnt <= topoff_cnt + 16'd1;
      end
   end

   // ==========================================
   // shipping mode
   logic shipping;
   logic [15:0] ship_cnt;

   always_ff @(posedge ref_clk) begin
      if (reset || !sw_off) begin
         shipping <= 1'b0;
         ship_cnt <= '0;
      end else if (!sw_delay || ship_cnt >= `SHIP_DELAY_S) begin
         shipping <= 1'b1;
      end else if (sec_tick) begin
         ship_cnt <= ship_cnt + 16'd1;
      end
   end

   // ==========================================
   // status and pins
   logic [1:0] charge_phase_field;
   logic [1:0] charge_fault_field;
   logic blink;

   always_comb begin
      unique case (state)
         charge_pkg::ST_CHARGING:
            charge_phase_field = ain.vbat_above_precharge ? 2'b10 : 2'b01;
         charge_pkg::ST_TOPOFF, charge_pkg::ST_DONE:
            charge_phase_field = 2'b11;
         default: charge_phase_field = 2'b00;
      endcase
   end
   assign charge_fault_field = in_fault ? 2'b11 : 2'b00;

   wire input_good_flag = ain.vbus_above_uvlo && ain.vbus_above_bat && ain.vbus_below_ov
                          && ain.not_poor_source && ain.src_detect_done;
   wire next_switch_on = !shipping && !(in_done && !ain.supplement_req);
   wire charging_now = in_charging || in_topoff;
   wire suspend_now = in_fault || ain.fault_present;
   wire next_oe = (indicator_function_sel != 2'b11)
                  && (suspend_now ? blink : charging_now);

   wire [15:0] status_word = {7'h00, shipping, battery_switch_on, input_good_flag,
                              ain.sys_at_min, in_topoff, charge_fault_field,
                              charge_phase_field};
   wire [15:0] read_mux = (reg_addr == `CTRL_ADDR) ? ctrl
                        : (reg_addr == `STATUS_ADDR) ? status_word : 16'h0000;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         blink <= 1'b0;
         battery_switch_on <= 1'b1;
         input_good_pin <= 1'b1;
         indicator_out <= 1'b0;
         indicator_oe <= 1'b0;
         reg_rdata <= '0;
      end else begin
         blink <= blink ^ blink_tick;
         battery_switch_on <= next_switch_on;
         input_good_pin <= !input_good_flag;
         indicator_out <= 1'b0;
         indicator_oe <= next_oe;
         reg_rdata <= reg_rd ? read_mux : 16'h0000;
      end
   end

   // ==========================================
   // checks
   a_term_phase: assert property (@(posedge ref_clk) disable iff (reset)
      enter_term |=> charge_phase_field == 2'b11 && host_event)
      else $error("termination did not set phase and event");
   a_no_term_reg: assert property (@(posedge ref_clk) disable iff (reset)
      in_charging && reg_active |=> !(in_topoff || in_done))
      else $error("termination during regulation");
   a_no_term_dis: assert property (@(posedge ref_clk) disable iff (reset)
      in_charging && !term_en |=> !(in_topoff || in_done))
      else $error("termination while disabled");
   a_topoff_hold: assert property (@(posedge ref_clk) disable iff (reset)
      in_topoff && suspended && !charge_en_rise && !reg_reset_wr |=> $stable(topoff_cnt))
      else $error("top-off counted while suspended");
   a_expiry_fault: assert property (@(posedge ref_clk) disable iff (reset)
      expire |=> charge_fault_field == 2'b11 && host_event)
      else $error("expiry did not raise fault");
   a_timer_off: assert property (@(posedge ref_clk) disable iff (reset)
      in_charging && !timer_en |=> !in_fault)
      else $error("fault with timer disabled");
   a_safety_freeze: assert property (@(posedge ref_clk) disable iff (reset)
      in_charging && suspended && !charge_en_rise |=> $stable(safety_cnt))
      else $error("safety timer moved during fault");
   a_restart_clear: assert property (@(posedge ref_clk) disable iff (reset)
      charge_en_rise |=> safety_cnt == 17'h00000)
      else $error("restart did not clear safety timer");
   a_ship_now: assert property (@(posedge ref_clk) disable iff (reset)
      sw_off && !sw_delay && !reg_reset_wr && !ctrl_wr && !adapter_rise
      |=> ##1 !battery_switch_on)
      else $error("switch not off in shipping");
   a_input_good: assert property (@(posedge ref_clk) disable iff (reset)
      !input_good_pin |-> $past(input_good_flag))
      else $error("input good pin low without qualification");
   a_half_rate: assert property (@(posedge ref_clk) disable iff (reset)
      half_active && !half_phase && !charge_en_rise |=> $stable(safety_cnt))
      else $error("safety timer counted on a skipped tick");
   a_topoff_clear: assert property (@(posedge ref_clk) disable iff (reset)
      reg_reset_wr |=> topoff_cnt == 16'h0000)
      else $error("register reset did not clear top-off timer");
   a_ship_exit: assert property (@(posedge ref_clk) disable iff (reset)
      !sw_off |=> !shipping)
      else $error("shipping held after switch off bit cleared");
   a_switch_done: assert property (@(posedge ref_clk) disable iff (reset)
      in_done && !ain.supplement_req |=> !battery_switch_on)
      else $error("battery switch on after charge done");
   a_event_pulse: assert property (@(posedge ref_clk) disable iff (reset)
      host_event |=> !host_event)
      else $error("host event longer than one cycle");
   a_blink_off: assert property (@(posedge ref_clk) disable iff (reset)
      indicator_function_sel == 2'b11 |=> !indicator_oe)
      else $error("indicator driven while disabled");
endmodule : charge_cycle_timing_and_status

//--- design/charge_defines.svh
// register offsets, field positions, reset values and timing counts for the charge timing block
// assumes a 10 MHz core clock and a 16-bit register port with 4-bit addresses
//
// Functional notes
// - terminate above recharge level, below termination current
// - charge done turns battery switch off unless supplement requested
// - termination sets phase 11, pulses host event
// - no termination during input or thermal regulation
// - termination enable 0 blocks termination
// - top-off timer runs, running flag readable
// - top-off pauses, halves with safety timer
// - top-off clears on enable, termination, reset
// - top-off length latched at termination
// - event at top-off start and expiry
// - safety limit 2h low battery, else selected
// - safety expiry sets fault 11, pulses event
// - timer enable 0 disables safety timer
// - regulation halves safety rate unless disabled
// - fault freezes safety timer, resumes later
// - charge enable toggle resets safety timer
// - flag high during minimum system regulation
// - switch off bit, immediate or delayed
// - shipping exits on adapter, clear, reset
// - input good only when all qualifications hold
// - phase codes 00 off 01 pre 10 fast 11 done
`ifndef CHARGE_DEFINES_SVH
`define CHARGE_DEFINES_SVH

// ==========================================
// register map
`define CTRL_ADDR 4'h0
`define STATUS_ADDR 4'h4
`define CTRL_RESET 16'h010f

// ==========================================
// control fields
`define CTRL_TERM_EN 0
`define CTRL_TIMER_EN 1
`define CTRL_HALF_RATE 2
`define CTRL_CHG_EN 3
`define CTRL_SW_OFF 4
`define CTRL_SW_DELAY 5
`define CTRL_REG_RESET 6
`define CTRL_FAST_LSB 8
`define CTRL_TOPOFF_LSB 10
`define CTRL_IND_LSB 12

// ==========================================
// status fields
`define STAT_PHASE_LSB 0
`define STAT_FAULT_LSB 2
`define STAT_TOPOFF 4
`define STAT_MIN_SYSTEM_VOLTAGE_FIELD 5
`define STAT_INPUT_GOOD 6
`define STAT_SWITCH_ON 7
`define STAT_SHIPPING 8

// ==========================================
// timing
`define CLK_PERIOD_NS 100
`define TICK_TIME_NS 1000000000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define BLINK_HALF_NS 500000000
`define BLINK_HALF_CYCLES (`BLINK_HALF_NS / `CLK_PERIOD_NS)
`define SAFETY_LOW_S 17'd7200
`define SAFETY_5H_S 17'd18000
`define SAFETY_10H_S 17'd36000
`define SAFETY_15H_S 17'd54000
`define SAFETY_20H_S 17'd72000
`define TOPOFF_15M_S 16'd900
`define TOPOFF_30M_S 16'd1800
`define TOPOFF_45M_S 16'd2700
`define SHIP_DELAY_S 16'd10

`endif

//--- design/charge_pkg.sv
// types shared by the charge timing block
// assumes charge_defines.svh supplies the numeric constants
package charge_pkg;

   // ==========================================
   // conditioned analog comparator outcomes
   typedef struct packed {
      logic vbat_above_recharge;
      logic ichg_below_term;
      logic in_current_reg;
      logic in_voltage_reg;
      logic thermal_reg;
      logic vbat_above_low;
      logic vbat_above_precharge;
      logic fault_present;
      logic sys_at_min;
      logic vbus_above_uvlo;
      logic vbus_above_bat;
      logic vbus_below_ov;
      logic not_poor_source;
      logic src_detect_done;
      logic adapter_present;
      logic supplement_req;
   } analog_in_t;

   // ==========================================
   // charge cycle states
   typedef enum logic [2:0] {
      ST_DISABLED,
      ST_CHARGING,
      ST_TOPOFF,
      ST_DONE,
      ST_FAULT
   } cycle_state_t;

endpackage : charge_pkg

//--- design/tick_divider.sv
// free running divider giving a one-cycle tick every PERIOD cycles
// assumes a single clock and synchronous active-high reset
`timescale 1ns/10ps
module tick_divider #(
   parameter int unsigned PERIOD = 10
) (
   input wire logic ref_clk,
   input wire logic reset,
   output logic tick
);
   logic [31:0] count;
   wire last = (count == 32'(PERIOD - 1));

   always_ff @(posedge ref_clk) begin
      if (reset || last) begin
         count <= '0;
      end else begin
         count <= count + 32'd1;
      end
   end

   always_ff @(posedge ref_clk) begin
      tick <= !reset && last;
   end
endmodule : tick_divider

//--- verif/charge_host_model.sv
// host processor model: single-cycle register writes and reads
// assumes read data stand only in the cycle after the read strobe
`timescale 1ns/10ps
module charge_host_model (
   input wire logic ref_clk,
   output logic [3:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata
);
   // ==========================================
   // idle levels
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // ==========================================
   // bus cycles
   // data is inverted after a write so a late sample never sees a stale match
   task automatic wr(input logic [3:0] addr, input logic [15:0] data);
      @(posedge ref_clk);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~data;
   endtask : wr

   task automatic rd(input logic [3:0] addr, output logic [15:0] data);
      @(posedge ref_clk);
      reg_addr <= addr;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      data = reg_rdata;
   endtask : rd
endmodule : charge_host_model

//--- verif/tb_charge_cycle_timing_and_status.sv
// self-checking bench for the charge timing block
// assumes the host model drives the register port; tick and blink periods are shortened
`timescale 1ns/10ps
`include "charge_defines.svh"
module tb_charge_cycle_timing_and_status;
   // ==========================================
   // signals
   localparam int LIMIT = 95000;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic reg_wr;
   logic reg_rd;
   logic charge_ce_n = 1'b1;
   charge_pkg::analog_in_t analog_in = '0;
   logic host_event;
   logic battery_switch_on;
   logic input_good_pin;
   logic indicator_out;
   logic indicator_oe;
   logic [15:0] val;
   int fail_count = 0;
   int checked = 0;
   int events = 0;
   int cycles = 0;
   int ev0;

   // ==========================================
   // instances
   // a 4-cycle tick keeps the two-hour limit near 28800 cycles
   charge_cycle_timing_and_status #(.TICK_CYCLES(4), .BLINK_HALF_CYCLES(3)) i_dut (
      .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .charge_ce_n(charge_ce_n),
      .analog_in(analog_in), .host_event(host_event), .battery_switch_on(battery_switch_on),
      .input_good_pin(input_good_pin), .indicator_out(indicator_out),
      .indicator_oe(indicator_oe));
   charge_host_model i_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   always #50 ref_clk = ~ref_clk;

   // event pulses are counted mid-cycle, clear of the launching edge
   always @(negedge ref_clk) begin
      cycles++;
      if (host_event === 1'b1) begin
         events++;
      end
      if (cycles == LIMIT) begin
         fail_count++;
         end_of_test();
      end
   end

   // ==========================================
   // helpers
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic stat(input logic [15:0] mask, input logic [15:0] exp);
      i_host.rd(`STATUS_ADDR, val);
      chk(val & mask, exp);
   endtask : stat

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   task automatic do_reset();
      @(posedge ref_clk);
      reset <= 1'b1;
      charge_ce_n <= 1'b1;
      analog_in <= '0;
      cyc(10);
      reset <= 1'b0;
      cyc(1);
   endtask : do_reset

   task automatic blink();
      logic b;
      b = indicator_oe;
      cyc(3);
      chk(indicator_oe ^ b, 16'h0001);
   endtask : blink

   // ==========================================
   // scenarios
   task automatic t_regs();
      i_host.rd(`CTRL_ADDR, val);
      chk(val, `CTRL_RESET);
      i_host.rd(4'h2, val);
      chk(val, 16'h0000);
      stat(16'h0083, 16'h0080);
      i_host.wr(`CTRL_ADDR, 16'h3f3f);
      i_host.rd(`CTRL_ADDR, val);
      chk(val, 16'h3f3f);
      i_host.wr(`CTRL_ADDR, 16'h0040);
      i_host.rd(`CTRL_ADDR, val);
      chk(val, `CTRL_RESET);
   endtask : t_regs

   task automatic t_charge();
      do_reset();
      charge_ce_n <= 1'b0;
      analog_in.vbat_above_low <= 1'b1;
      cyc(8);
      stat(16'h0003, 16'h0001);
      chk(indicator_oe, 16'h0001);
      chk(indicator_out, 16'h0000);
      analog_in.vbat_above_precharge <= 1'b1;
      analog_in.vbat_above_recharge <= 1'b1;
      cyc(8);
      stat(16'h0003, 16'h0002);
      i_host.wr(`CTRL_ADDR, 16'h310f);
      cyc(6);
      chk(indicator_oe, 16'h0000);
      ev0 = events;
      for (int i = 0; i < 3; i++) begin
         analog_in[14:11] <= 4'b1000 | (4'b0100 >> i);
         cyc(12);
         analog_in[14:11] <= 4'h0;
         cyc(6);
      end
      chk(events - ev0, 16'h0000);
      i_host.wr(`CTRL_ADDR, 16'h010e);
      analog_in.ichg_below_term <= 1'b1;
      cyc(12);
      chk(events - ev0, 16'h0000);
      i_host.wr(`CTRL_ADDR, 16'h010f);
      cyc(10);
      chk(events - ev0, 16'h0001);
      stat(16'h0003, 16'h0003);
      chk(battery_switch_on, 16'h0000);
      chk(indicator_oe, 16'h0000);
   endtask : t_charge

   task automatic t_topoff();
      do_reset();
      i_host.wr(`CTRL_ADDR, 16'h050f);
      ev0 = events;
      analog_in[15:14] <= 2'b11;
      analog_in[10:9] <= 2'b11;
      charge_ce_n <= 1'b0;
      cyc(12);
      chk(events - ev0, 16'h0001);
      stat(16'h0013, 16'h0013);
      // regulation doubles the segment, a short fault pauses it
      analog_in.in_current_reg <= 1'b1;
      analog_in.fault_present <= 1'b1;
      cyc(20);
      analog_in.fault_present <= 1'b0;
      // a longer setting written now must not stretch the running segment
      i_host.wr(`CTRL_ADDR, 16'h0d0f);
      cyc(3440);
      stat(16'h0010, 16'h0010);
      cyc(200);
      stat(16'h0010, 16'h0010);
      cyc(3700);
      stat(16'h0010, 16'h0000);
      chk(events - ev0, 16'h0002);
   endtask : t_topoff

   task automatic t_ship();
      do_reset();
      i_host.wr(`CTRL_ADDR, 16'h011f);
      cyc(6);
      chk(battery_switch_on, 16'h0000);
      stat(16'h0100, 16'h0100);
      i_host.wr(`CTRL_ADDR, 16'h010f);
      cyc(6);
      chk(battery_switch_on, 16'h0001);
      i_host.wr(`CTRL_ADDR, 16'h011f);
      cyc(6);
      analog_in.adapter_present <= 1'b1;
      cyc(8);
      chk(battery_switch_on, 16'h0001);
      i_host.wr(`CTRL_ADDR, 16'h013f);
      cyc(20);
      chk(battery_switch_on, 16'h0001);
      cyc(40);
      chk(battery_switch_on, 16'h0000);
      i_host.wr(`CTRL_ADDR, 16'h0040);
      cyc(6);
      chk(battery_switch_on, 16'h0001);
   endtask : t_ship

   task automatic t_flags();
      do_reset();
      analog_in.sys_at_min <= 1'b1;
      cyc(6);
      stat(16'h0020, 16'h0020);
      // each qualification dropped alone, then all held
      for (int i = 0; i < 6; i++) begin
         analog_in[6:2] <= 5'h1f & ~(5'h01 << i);
         cyc(6);
         stat(16'h0040, (i == 5) ? 16'h0040 : 16'h0000);
         chk(input_good_pin, (i == 5) ? 16'h0000 : 16'h0001);
      end
   endtask : t_flags

   task automatic t_safety();
      do_reset();
      ev0 = events;
      analog_in.vbat_above_precharge <= 1'b1;
      charge_ce_n <= 1'b0;
      cyc(14000);
      analog_in.fault_present <= 1'b1;
      cyc(10);
      blink();
      cyc(1990);
      analog_in.fault_present <= 1'b0;
      cyc(13800);
      stat(16'h000c, 16'h0000);
      chk(events - ev0, 16'h0000);
      i_host.wr(`CTRL_ADDR, 16'h010d);
      cyc(1500);
      stat(16'h000c, 16'h0000);
      i_host.wr(`CTRL_ADDR, 16'h010f);
      cyc(1500);
      stat(16'h000c, 16'h000c);
      chk(events - ev0, 16'h0001);
      blink();
   endtask : t_safety

   task automatic t_restart();
      do_reset();
      analog_in.vbat_above_precharge <= 1'b1;
      charge_ce_n <= 1'b0;
      cyc(15000);
      i_host.wr(`CTRL_ADDR, 16'h0107);
      i_host.wr(`CTRL_ADDR, 16'h010f);
      cyc(15000);
      stat(16'h000c, 16'h0000);
      charge_ce_n <= 1'b1;
      cyc(10);
      charge_ce_n <= 1'b0;
      cyc(15000);
      stat(16'h000c, 16'h0000);
   endtask : t_restart

   // ==========================================
   // main sequence
   initial begin
      do_reset();
      t_regs();
      t_charge();
      t_topoff();
      t_ship();
      t_flags();
      t_safety();
      t_restart();
      end_of_test();
   end
endmodule : tb_charge_cycle_timing_and_status
